// ==== rtl/supervisor_trap_delegation.v ====
// trap delegation, supervisor status view and supervisor interrupt control with axi4-lite access
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "trap_deleg_map.vh"
module supervisor_trap_delegation #(
    parameter N_LOCAL = 16
) (
    input wire sys_clk,
    input wire srst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire exc_valid,
    input wire [3:0] exc_code,
    input wire soft_irq_in,
    input wire timer_irq_in,
    input wire external_irq_in,
    input wire [2:0] machine_irq,
    input wire [N_LOCAL-1:0] local_irq,
    input wire sret,
    input wire mret,
    input wire [63:0] m_vector,
    output reg trap_valid,
    output reg trap_to_super,
    output reg [63:0] trap_cause,
    output reg [63:0] trap_target,
    output reg [1:0] priv_mode,
    output wire irq
);

// ----------------------------------------------------------------
// storage
// ----------------------------------------------------------------
localparam [31:0] LOC_MASK = ((32'h1 << N_LOCAL) - 32'h1) << 16;
localparam [31:0] IDELEG_MASK = `IDELEG_SUP_MASK | LOC_MASK;

reg [31:0] ideleg_r;
reg [31:0] edeleg_r;
reg [31:0] sie_r;
reg [31:0] sip_r;
reg [31:0] loc_en_r;
reg [63:0] scause_r;
reg [63:0] stvec_base_r;
reg stvec_mode_r;
reg st_sie_r;
reg st_mie_r;
reg st_supervisor_saved_enable_r;
reg st_mpie_r;
reg st_spp_r;
reg [1:0] st_mpp_r;
reg [1:0] irq_stat_r;
reg [1:0] irq_mask_r;

// ----------------------------------------------------------------
// bus slave: address and data are held until both are present
// ----------------------------------------------------------------
reg aw_held_r;
reg w_held_r;
reg [7:0] aw_addr_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;
wire do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
assign s_axi_awready = ~aw_held_r;
assign s_axi_wready = ~w_held_r;
assign s_axi_arready = ~s_axi_rvalid;

function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer k;
    begin
        merge = old;
        for (k = 0; k < 4; k = k + 1) begin
            if (strb[k])
                merge[k*8 +: 8] = data[k*8 +: 8];
        end
    end
endfunction

// machine view of status; the supervisor view is a masked read of the same bits
wire [31:0] mstatus_w = ({31'h0, st_sie_r} << `ST_SIE) | ({31'h0, st_mie_r} << `ST_MIE)
    | ({31'h0, st_supervisor_saved_enable_r} << `ST_SUPERVISOR_SAVED_ENABLE) | ({31'h0, st_mpie_r} << `ST_MPIE)
    | ({31'h0, st_spp_r} << `ST_SPP) | ({30'h0, st_mpp_r} << `ST_MPP_LO);
wire [31:0] sstatus_w = mstatus_w & `SSTATUS_MASK;
wire [31:0] wm = merge(32'h0, w_data_r, w_strb_r);
wire [31:0] wkeep = merge(32'hffff_ffff, 32'h0, w_strb_r);

// ----------------------------------------------------------------
// interrupt selection
// ----------------------------------------------------------------
wire [31:0] pend = ({16'h0, 16'h0} | (sip_r & `SIP_MASK))
    | ({31'h0, soft_irq_in} << 1) | ({31'h0, timer_irq_in} << `CODE_S_TIMER)
    | ({31'h0, external_irq_in} << `CODE_S_EXT)
    | ({31'h0, machine_irq[0]} << 3) | ({31'h0, machine_irq[1]} << 7)
    | ({31'h0, machine_irq[2]} << 11)
    | (({{(32-N_LOCAL){1'b0}}, local_irq} << 16) & LOC_MASK);
wire [31:0] ien = (sie_r & `SIE_MASK) | (loc_en_r & LOC_MASK) | 32'h0000_0888;
wire in_m = (priv_mode == `PRIV_M);
// delegated irq needs the supervisor global enable and its own enable
wire [31:0] to_s = ideleg_r & ien & {32{~in_m & st_sie_r}};
wire [31:0] to_m = ~ideleg_r & ien & {32{~in_m | st_mie_r}};
wire [31:0] elig = pend & (to_s | to_m);

reg irq_any;
reg [4:0] irq_code;
integer i;
always @* begin
    irq_any = 1'b0;
    irq_code = 5'h0;
    // the highest code wins; locals therefore beat the standard lines
    for (i = 0; i < 32; i = i + 1) begin
        if (elig[i]) begin
            irq_any = 1'b1;
            irq_code = i[4:0];
        end
    end
end

wire exc_deleg = edeleg_r[exc_code] & ~in_m;
wire irq_deleg = ideleg_r[irq_code] & ~in_m;
wire take = exc_valid | irq_any;
wire take_s = exc_valid ? exc_deleg : irq_deleg;
wire is_irq = ~exc_valid;
wire [4:0] code = exc_valid ? {1'b0, exc_code} : irq_code;
wire [63:0] cause_w = {is_irq, 58'h0, code};
wire [63:0] s_target = (stvec_mode_r & is_irq)
    ? stvec_base_r + {57'h0, code, 2'h0} : stvec_base_r;

// ----------------------------------------------------------------
// register update, traps override bus writes in the same cycle
// ----------------------------------------------------------------
always @(posedge sys_clk) begin
    if (srst) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        aw_addr_r <= 8'h00;
        w_data_r <= 32'h0000_0000;
        w_strb_r <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
        ideleg_r <= 32'h0000_0000;
        edeleg_r <= 32'h0000_0000;
        sie_r <= 32'h0000_0000;
        sip_r <= 32'h0000_0000;
        loc_en_r <= 32'h0000_0000;
        scause_r <= 64'h0;
        stvec_base_r <= 64'h0;
        stvec_mode_r <= 1'b0;
        st_sie_r <= 1'b0;
        st_mie_r <= 1'b0;
        st_supervisor_saved_enable_r <= 1'b0;
        st_mpie_r <= 1'b0;
        st_spp_r <= 1'b0;
        st_mpp_r <= `PRIV_U;
        priv_mode <= `PRIV_M;
        irq_stat_r <= 2'h0;
        irq_mask_r <= 2'h0;
        trap_valid <= 1'b0;
        trap_to_super <= 1'b0;
        trap_cause <= 64'h0;
        trap_target <= 64'h0;
    end else begin
        if (s_axi_awvalid & ~aw_held_r) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid & ~w_held_r) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            case ({aw_addr_r[7:2], 2'b00})
                `OFF_IDELEG_LO: ideleg_r <= ((ideleg_r & wkeep) | wm) & IDELEG_MASK;
                `OFF_EDELEG_LO: edeleg_r <= ((edeleg_r & wkeep) | wm) & `EDELEG_MASK;
                `OFF_IDELEG_HI, `OFF_EDELEG_HI, `OFF_SSTATUS_HI: ;
                `OFF_SSTATUS_LO: begin
                    // only supervisor fields can change through this view
                    if (w_strb_r[0]) begin
                        st_sie_r <= w_data_r[`ST_SIE];
                        st_supervisor_saved_enable_r <= w_data_r[`ST_SUPERVISOR_SAVED_ENABLE];
                    end
                    if (w_strb_r[1])
                        st_spp_r <= w_data_r[`ST_SPP];
                end
                `OFF_MSTATUS_LO: begin
                    if (w_strb_r[0]) begin
                        st_sie_r <= w_data_r[`ST_SIE];
                        st_mie_r <= w_data_r[`ST_MIE];
                        st_supervisor_saved_enable_r <= w_data_r[`ST_SUPERVISOR_SAVED_ENABLE];
                        st_mpie_r <= w_data_r[`ST_MPIE];
                    end
                    if (w_strb_r[1]) begin
                        st_spp_r <= w_data_r[`ST_SPP];
                        st_mpp_r <= w_data_r[`ST_MPP_HI:`ST_MPP_LO];
                    end
                end
                `OFF_SIE_LO: sie_r <= ((sie_r & wkeep) | wm) & `SIE_MASK;
                `OFF_SIP_LO: sip_r <= ((sip_r & wkeep) | wm) & `SIP_MASK;
                `OFF_SCAUSE_LO: scause_r[31:0] <= (scause_r[31:0] & wkeep) | wm;
                `OFF_SCAUSE_HI: scause_r[63:32] <= (scause_r[63:32] & wkeep) | wm;
                `OFF_STVEC_LO: begin
                    stvec_base_r[31:0] <= ((stvec_base_r[31:0] & wkeep) | wm) & 32'hffff_fffc;
                    // a reserved mode value falls back to direct
                    if (w_strb_r[0])
                        stvec_mode_r <= (w_data_r[1:0] == `STVEC_VECTORED);
                end
                `OFF_STVEC_HI: stvec_base_r[63:32] <= (stvec_base_r[63:32] & wkeep) | wm;
                `OFF_LOC_EN: loc_en_r <= ((loc_en_r & wkeep) | wm) & LOC_MASK;
                `OFF_PRIV: begin
                    if (w_strb_r[0] & (w_data_r[1:0] != 2'h2))
                        priv_mode <= w_data_r[1:0];
                end
                `OFF_IRQ_STAT: begin
                    if (w_strb_r[0])
                        irq_stat_r <= irq_stat_r & ~w_data_r[1:0];
                end
                `OFF_IRQ_MASK: begin
                    if (w_strb_r[0])
                        irq_mask_r <= w_data_r[1:0];
                end
                default: s_axi_bresp <= `RESP_SLVERR;
            endcase
        end
        // trap entry and return take priority over the bus on shared fields
        trap_valid <= take;
        if (take) begin
            trap_cause <= cause_w;
            if (take_s) begin
                trap_to_super <= 1'b1;
                trap_target <= s_target;
                scause_r <= cause_w;
                st_supervisor_saved_enable_r <= st_sie_r;
                st_sie_r <= 1'b0;
                st_spp_r <= priv_mode[0];
                priv_mode <= `PRIV_S;
            end else begin
                trap_to_super <= 1'b0;
                trap_target <= m_vector;
                st_mpie_r <= st_mie_r;
                st_mie_r <= 1'b0;
                st_mpp_r <= priv_mode;
                priv_mode <= `PRIV_M;
            end
        end else if (mret) begin
            st_mie_r <= st_mpie_r;
            st_mpie_r <= 1'b1;
            priv_mode <= st_mpp_r;
            st_mpp_r <= `PRIV_U;
        end else if (sret) begin
            st_sie_r <= st_supervisor_saved_enable_r;
            st_supervisor_saved_enable_r <= 1'b1;
            priv_mode <= {1'b0, st_spp_r};
            st_spp_r <= 1'b0;
        end
        // event set wins over a same-cycle write-one clear
        if (take & take_s)
            irq_stat_r[0] <= 1'b1;
        if (take & ~take_s)
            irq_stat_r[1] <= 1'b1;
    end
end

assign irq = |(irq_stat_r & irq_mask_r);

// ----------------------------------------------------------------
// read channel
// ----------------------------------------------------------------
reg [31:0] rd_mux;
reg rd_err;
always @* begin
    rd_err = 1'b0;
    case ({s_axi_araddr[7:2], 2'b00})
        `OFF_IDELEG_LO: rd_mux = ideleg_r;
        `OFF_EDELEG_LO: rd_mux = edeleg_r;
        `OFF_SSTATUS_LO: rd_mux = sstatus_w;
        `OFF_MSTATUS_LO: rd_mux = mstatus_w;
        `OFF_SIE_LO: rd_mux = sie_r;
        `OFF_SIP_LO: rd_mux = pend & `SIP_MASK;
        `OFF_SCAUSE_LO: rd_mux = scause_r[31:0];
        `OFF_SCAUSE_HI: rd_mux = scause_r[63:32];
        `OFF_STVEC_LO: rd_mux = {stvec_base_r[31:2], 1'b0, stvec_mode_r};
        `OFF_STVEC_HI: rd_mux = stvec_base_r[63:32];
        `OFF_LOC_EN: rd_mux = loc_en_r;
        `OFF_PRIV: rd_mux = {30'h0, priv_mode};
        `OFF_IRQ_STAT: rd_mux = {30'h0, irq_stat_r};
        `OFF_IRQ_MASK: rd_mux = {30'h0, irq_mask_r};
        `OFF_IDELEG_HI, `OFF_EDELEG_HI, `OFF_SSTATUS_HI: rd_mux = 32'h0000_0000;
        default: begin
            rd_mux = 32'h0000_0000;
            rd_err = 1'b1;
        end
    endcase
end

always @(posedge sys_clk) begin
    if (srst) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule // supervisor_trap_delegation

// ==== rtl/trap_deleg_map.vh ====
// register offsets, field positions, masks and reset values of the trap delegation block
`ifndef TRAP_DELEG_MAP_VH
`define TRAP_DELEG_MAP_VH

// ----------------------------------------------------------------
// register byte offsets on the axi4-lite slave
// ----------------------------------------------------------------
`define OFF_IDELEG_LO 8'h00
`define OFF_IDELEG_HI 8'h04
`define OFF_EDELEG_LO 8'h08
`define OFF_EDELEG_HI 8'h0c
`define OFF_SSTATUS_LO 8'h10
`define OFF_SSTATUS_HI 8'h14
`define OFF_MSTATUS_LO 8'h18
`define OFF_SIE_LO 8'h1c
`define OFF_SIP_LO 8'h20
`define OFF_SCAUSE_LO 8'h24
`define OFF_SCAUSE_HI 8'h28
`define OFF_STVEC_LO 8'h2c
`define OFF_STVEC_HI 8'h30
`define OFF_LOC_EN 8'h34
`define OFF_PRIV 8'h38
`define OFF_IRQ_STAT 8'h3c
`define OFF_IRQ_MASK 8'h40

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define ST_SIE 1
`define ST_MIE 3
`define ST_SUPERVISOR_SAVED_ENABLE 5
`define ST_MPIE 7
`define ST_SPP 8
`define ST_MPP_LO 11
`define ST_MPP_HI 12

// ----------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------
`define IDELEG_SUP_MASK 32'h0000_0222
`define EDELEG_MASK 32'h0000_b3ff
`define SIE_MASK 32'h0000_0222
`define SIP_MASK 32'h0000_0222
`define SSTATUS_MASK 32'h0000_0122
`define IRQ_EVT_MASK 32'h0000_0003
`define PRIV_U 2'h0
`define PRIV_S 2'h1
`define PRIV_M 2'h3
`define CODE_S_TIMER 5
`define CODE_S_EXT 9
`define STVEC_VECTORED 2'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== test/supervisor_trap_delegation_asserts.sv ====
// concurrent checker for the trap delegation block
`timescale 1ns/100ps
module trap_deleg_chk (
    input wire sys_clk,
    input wire srst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire exc_valid,
    input wire [3:0] exc_code,
    input wire trap_valid,
    input wire trap_to_super,
    input wire [63:0] trap_cause,
    input wire [1:0] priv_mode
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // both halves are latched first, the write lands one edge later, then bvalid shows
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
    // ----------------------------------------------------------------
    // trap routing
    // ----------------------------------------------------------------
    // no disable here, the default one would hide the reset itself
    reset_state_a: assert property (disable iff (1'h0) srst |=>
        priv_mode == 2'h3 && !trap_valid) else $error("reset state wrong");
    machine_exc_a: assert property (exc_valid && priv_mode == 2'h3 |=> trap_valid
        && !trap_to_super && trap_cause == {60'h0, $past(exc_code)})
        else $error("machine exception misrouted");
    exc_cause_a: assert property (exc_valid |=> trap_valid && !trap_cause[63])
        else $error("exception cause marked as interrupt");
    super_priv_a: assert property (trap_valid && trap_to_super |-> priv_mode == 2'h1)
        else $error("supervisor trap without supervisor mode");
    cover property (trap_valid && trap_to_super && trap_cause[63]);
    cover property (trap_valid && !trap_to_super);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule // trap_deleg_chk

bind supervisor_trap_delegation trap_deleg_chk u_trap_deleg_chk (.sys_clk, .srst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .exc_valid, .exc_code, .trap_valid, .trap_to_super, .trap_cause,
    .priv_mode);

// ==== test/tb_supervisor_trap_delegation.sv ====
// self-checking bench for the trap delegation block
`timescale 1ns/100ps
module tb_supervisor_trap_delegation;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
    logic sys_clk;
    logic srst = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sret = 1'h0, mret = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf, exc_code = 4'h0;
    logic exc_valid = 1'h0, soft_irq_in = 1'h0, timer_irq_in = 1'h0, external_irq_in = 1'h0;
    logic [2:0] machine_irq = 3'h0;
    logic [15:0] local_irq = 16'h0;
    logic [63:0] m_vector = 64'h8000;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, priv_mode;
    wire [31:0] s_axi_rdata;
    wire trap_valid, trap_to_super, irq;
    wire [63:0] trap_cause, trap_target;
    int n_fail = 0, n_tests = 0, n_trap = 0, n0 = 0, cyc = 0;
    logic t_sup;
    logic [63:0] t_cause, t_tgt;
    row_t rows [9];
    supervisor_trap_delegation #(.N_LOCAL(16)) u_supervisor_trap_delegation (.sys_clk, .srst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .exc_valid, .exc_code, .soft_irq_in, .timer_irq_in,
        .external_irq_in, .machine_irq, .local_irq, .sret, .mret, .m_vector, .trap_valid,
        .trap_to_super, .trap_cause, .trap_target, .priv_mode, .irq);
    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'h1) begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        // each channel lets go only at its own handshake edge
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp === er, "write response");
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        s_axi_rready <= 1'h0;
        chk(s_axi_rresp === er && (er != 2'h0 || s_axi_rdata === e), "read value");
    endtask
    task automatic take_exc(input logic [3:0] c);
        @(posedge sys_clk);
        exc_valid <= 1'h1;
        exc_code <= c;
        @(posedge sys_clk);
        exc_valid <= 1'h0;
    endtask
    task automatic trap_chk(input logic s, input logic [63:0] c, input logic [63:0] t);
        repeat (3) @(posedge sys_clk);
        chk(t_sup === s && t_cause === c && t_tgt === t, "trap routing");
    endtask
    // trap pulses last one cycle, so they are latched here for later checks
    always @(posedge sys_clk) begin
        cyc++;
        if (trap_valid === 1'h1) begin
            n_trap++;
            t_sup = trap_to_super;
            t_cause = trap_cause;
            t_tgt = trap_target;
        end
        if (cyc == 5000) begin
            n_fail++;
            $display("MISMATCH %0t timeout", $time);
            wrap_up();
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rows = '{
            '{8'h00, 32'hffffffff, 32'hffff0222, 2'h0},
            '{8'h04, 32'hffffffff, 32'h0, 2'h0},
            '{8'h08, 32'hffffffff, 32'hb3ff, 2'h0},
            '{8'h0c, 32'hffffffff, 32'h0, 2'h0},
            '{8'h1c, 32'hffffffff, 32'h222, 2'h0},
            '{8'h10, 32'hffffffff, 32'h122, 2'h0},
            '{8'h18, 32'h18aa, 32'h18aa, 2'h0},
            '{8'h2c, 32'h1001, 32'h1001, 2'h0},
            '{8'h80, 32'hffffffff, 32'h0, 2'h2}};
        repeat (4) @(posedge sys_clk);
        srst <= 1'h0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rows[i].r);
            rd(rows[i].a, rows[i].e, rows[i].r);
        end
        rd(8'h10, 32'h22, 2'h0);
        srst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'h0;
        chk(priv_mode === 2'h3, "reset privilege");
        for (int i = 0; i < 4; i++) rd(8'(i * 8), 32'h0, 2'h0);
        take_exc(4'h2);
        trap_chk(1'h0, 64'h2, 64'h8000);
        wr(8'h08, 32'h4, 2'h0);
        wr(8'h2c, 32'h1000, 2'h0);
        wr(8'h18, 32'h2, 2'h0);
        wr(8'h38, 32'h0, 2'h0);
        take_exc(4'h2);
        trap_chk(1'h1, 64'h2, 64'h1000);
        rd(8'h18, 32'h20, 2'h0);
        @(posedge sys_clk);
        sret <= 1'h1;
        @(posedge sys_clk);
        sret <= 1'h0;
        repeat (2) @(posedge sys_clk);
        chk(priv_mode === 2'h0, "return privilege");
        take_exc(4'h3);
        trap_chk(1'h0, 64'h3, 64'h8000);
        wr(8'h00, 32'h220, 2'h0);
        wr(8'h1c, 32'h220, 2'h0);
        wr(8'h2c, 32'h1001, 2'h0);
        wr(8'h18, 32'h2, 2'h0);
        wr(8'h38, 32'h0, 2'h0);
        timer_irq_in <= 1'h1;
        trap_chk(1'h1, 64'h8000_0000_0000_0005, 64'h1014);
        n0 = n_trap;
        external_irq_in <= 1'h1;
        repeat (8) @(posedge sys_clk);
        chk(n_trap == n0, "taken without global enable");
        timer_irq_in <= 1'h0;
        external_irq_in <= 1'h0;
        wr(8'h00, 32'h10000, 2'h0);
        wr(8'h34, 32'h10000, 2'h0);
        wr(8'h18, 32'h2, 2'h0);
        local_irq <= 16'h1;
        trap_chk(1'h1, 64'h8000_0000_0000_0010, 64'h1040);
        local_irq <= 16'h0;
        wr(8'h00, 32'h2, 2'h0);
        wr(8'h1c, 32'h2, 2'h0);
        wr(8'h18, 32'h2, 2'h0);
        wr(8'h20, 32'h2, 2'h0);
        trap_chk(1'h1, 64'h8000_0000_0000_0001, 64'h1004);
        wr(8'h20, 32'h0, 2'h0);
        wr(8'h40, 32'h0, 2'h0);
        chk(irq === 1'h0, "irq not masked");
        wr(8'h40, 32'h1, 2'h0);
        chk(irq === 1'h1, "irq not raised");
        wr(8'h3c, 32'h1, 2'h0);
        chk(irq === 1'h0, "irq not cleared");
        rd(8'h3c, 32'h2, 2'h0);
        // undelegated supervisor and machine lines must both land in machine mode
        wr(8'h00, 32'h0, 2'h0);
        soft_irq_in <= 1'h1;
        trap_chk(1'h0, 64'h8000_0000_0000_0001, 64'h8000);
        soft_irq_in <= 1'h0;
        @(posedge sys_clk);
        mret <= 1'h1;
        @(posedge sys_clk);
        mret <= 1'h0;
        repeat (2) @(posedge sys_clk);
        chk(priv_mode === 2'h1, "machine return privilege");
        machine_irq <= 3'h2;
        trap_chk(1'h0, 64'h8000_0000_0000_0007, 64'h8000);
        machine_irq <= 3'h0;
        wrap_up();
    end
endmodule // tb_supervisor_trap_delegation
